// >>> rtl/reset_pin_filter.sv
/*
  synchroniser and pulse-width qualifier for the active-low reset pin.
  assumes the pin is asynchronous to clk_in and drives a plain level.
*/
`timescale 1ns/1ps
module reset_pin_filter (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic [19:0] min_cycles_in,
  output logic low_long_out,
  output logic released_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic sync1_reg;
  logic sync2_reg;
  logic [19:0] low_cnt_reg;
  logic [19:0] low_cnt_next;
  logic low_long_next;
  logic released_next;

  // two-flop synchroniser, first stage read only by second
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= reset_pin_n_in;
      sync2_reg <= sync1_reg;
    end
  end

  // count low cycles, qualify against the minimum width
  always_comb
  begin
    low_cnt_next = low_cnt_reg;
    low_long_next = low_long_out;
    released_next = 1'b0;
    if (!sync2_reg)
    begin
      if (low_cnt_reg != 20'hfffff)
        low_cnt_next = low_cnt_reg + 20'h00001;
      if ((low_cnt_reg + 20'h00001) >= min_cycles_in)
        low_long_next = 1'b1; // [RULE14]
    end
    else
    begin
      low_cnt_next = 20'h00000;
      low_long_next = 1'b0;
      released_next = low_long_out; // short glitches never release [RULE14]
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      low_cnt_reg <= 20'h00000;
      low_long_out <= 1'b0;
      released_out <= 1'b0;
    end
    else
    begin
      low_cnt_reg <= low_cnt_next;
      low_long_out <= low_long_next;
      released_out <= released_next;
    end
  end

endmodule

// >>> rtl/reset_recovery_pkg.sv
/*
  constants for the reset recovery sequencer: timing counts, register
  layouts and sequencer states.
  assumes a 100 MHz device clock and an active-low external reset pin.
*/
// Functional notes
// RULE1: at power-up the external source holds reset low at least 1 ms after supply is steady.
// RULE2: during power-on reset the device loads configuration, clears registers, readies flash.
// RULE3: after reset rises the device stays in reset up to 120 ns; no access before that ends.
// RULE4: on power-up the flash control machine enters read-array mode.
// RULE5: during power-up reset flash selects and the write strobe are held inactive.
// RULE6: no flash write cycle may start while the supply is below the write lockout threshold.
// RULE7: a warm reset is a low pulse on the reset input of at least 150 ns.
// RULE8: logic outputs stay valid in warm reset and become valid once configuration is loaded.
// RULE9: on reset I/O pins become inputs, address-out and data are tri-stated; power-down differs.
// RULE10: power mode registers zero and two clear only on power-on reset; others on both.
// RULE11: the memory-mapping register reloads its configured value with the code bit cleared.
// RULE12: an external reset aborts flash program or erase and returns to read within 25 us.
// RULE13: a power-good flag set after first configuration load tells power-on from warm reset.
// RULE14: the reset input is active low, synchronised, and glitches below warm minimum ignored.
package reset_recovery_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int clk_period_ps = 10000;
  localparam int poweron_pulse_min_ns = 1000000;
  localparam int warm_pulse_min_ns = 150;
  localparam int recovery_max_ns = 120;
  localparam int abort_max_us = 25;
  // least times round up, longest times round down
  localparam int poweron_cycles = (poweron_pulse_min_ns * 1000 + clk_period_ps - 1)
    / clk_period_ps;
  localparam int warm_cycles = (warm_pulse_min_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int recovery_cycles = (recovery_max_ns * 1000) / clk_period_ps;
  localparam int abort_cycles = (abort_max_us * 1000000) / clk_period_ps;
  localparam int config_load_cycles = 16;
  localparam int cnt_w = 20;

  ////////////////////////////////////////////////////////////////////////////
  // register layout
  localparam int reg_w = 8;
  localparam logic [7:0] reg_clear_val = 8'h00;
  localparam int sram_code_space_bit = 0;
  localparam int port_w = 8;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    st_poweron = 3'b000,
    st_load = 3'b001,
    st_hold = 3'b010,
    st_recover = 3'b011,
    st_run = 3'b100
  } seq_state_t;

  // flash control states
  typedef enum logic [1:0] {
    fl_read = 2'b00,
    fl_busy = 2'b01,
    fl_abort = 2'b10
  } flash_state_t;

endpackage

// >>> rtl/reset_recovery_sequencer.sv
/*
  reset recovery sequencer: tells power-on from warm reset, loads
  configuration, clears registers by reset type, makes pins safe, holds
  off memory access, and forces the flash back to read mode.
  assumes the reset pin is active low and the supply monitor is a level.
*/
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module reset_recovery_sequencer #(
  parameter int poweron_cycles_p = reset_recovery_pkg::poweron_cycles,
  parameter int abort_cycles_p = reset_recovery_pkg::abort_cycles
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic below_lockout_in,
  input wire logic power_down_in,
  input wire logic [7:0] vm_init_in,
  input wire logic flash_start_in,
  input wire logic flash_done_in,
  input wire logic [1:0] reg_wr_sel_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] pld_eqn_in,
  input wire logic [7:0] io_out_in,
  input wire logic [7:0] io_dir_in,
  output logic in_reset_out,
  output logic access_ok_out,
  output logic poweron_out,
  output logic power_good_out,
  output logic config_loaded_out,
  output logic flash_read_mode_out,
  output logic flash_busy_out,
  output logic flash_abort_out,
  output logic write_start_out,
  output logic select_inhibit_out,
  output logic [7:0] power_mode_reg_zero_out,
  output logic [7:0] power_mode_reg_two_out,
  output logic [7:0] memory_mapping_reg_out,
  output logic [7:0] other_reg_out,
  output logic [7:0] pld_out,
  output logic [7:0] io_out,
  output logic [7:0] io_oe_n_out,
  output logic addr_oe_n_out,
  output logic data_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin qualification
  logic low_long;
  logic released;
  logic [19:0] min_cycles;

  // power-on pulse minimum until power is good, then the warm minimum
  assign min_cycles = power_good_out ? 20'(reset_recovery_pkg::warm_cycles)
    : 20'(poweron_cycles_p);

  reset_pin_filter u_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reset_pin_n_in(reset_pin_n_in),
    .min_cycles_in(min_cycles),
    .low_long_out(low_long),
    .released_out(released)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  reset_recovery_pkg::seq_state_t state_reg;
  reset_recovery_pkg::seq_state_t state_next;
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic power_good_next;
  logic cfg_next;
  logic poweron_next;

  // walk power-on, config load, hold, recovery, run
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    power_good_next = power_good_out;
    cfg_next = config_loaded_out;
    poweron_next = poweron_out;
    case (state_reg)
      reset_recovery_pkg::st_poweron:
      begin
        state_next = reset_recovery_pkg::st_load;
        cnt_next = 20'h00000;
        poweron_next = 1'b1;
      end
      reset_recovery_pkg::st_load:
      begin
        cnt_next = cnt_reg + 20'h00001;
        if (cnt_reg + 20'h00001 >= 20'(reset_recovery_pkg::config_load_cycles))
        begin
          cfg_next = 1'b1; // [RULE2] [RULE8]
          power_good_next = 1'b1; // [RULE13]
          state_next = reset_recovery_pkg::st_hold;
        end
      end
      reset_recovery_pkg::st_hold:
      begin
        cnt_next = 20'h00000;
        if (released)
          state_next = reset_recovery_pkg::st_recover;
        else if (!low_long && poweron_out)
          state_next = reset_recovery_pkg::st_hold; // wait for a pulse past the warm minimum, power good being already set by st_load [RULE1]
      end
      reset_recovery_pkg::st_recover:
      begin
        cnt_next = cnt_reg + 20'h00001;
        if (low_long)
          state_next = reset_recovery_pkg::st_hold;
        else if (cnt_reg + 20'h00001 >= 20'(reset_recovery_pkg::recovery_cycles))
        begin
          state_next = reset_recovery_pkg::st_run; // [RULE3]
          poweron_next = 1'b0;
        end
      end
      reset_recovery_pkg::st_run:
      begin
        if (low_long)
          state_next = reset_recovery_pkg::st_hold; // warm reset [RULE7]
      end
      default:
        state_next = reset_recovery_pkg::st_poweron;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= reset_recovery_pkg::st_poweron;
      cnt_reg <= 20'h00000;
      power_good_out <= 1'b0;
      config_loaded_out <= 1'b0;
      poweron_out <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      power_good_out <= power_good_next;
      config_loaded_out <= cfg_next;
      poweron_out <= poweron_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash control
  reset_recovery_pkg::flash_state_t fl_reg;
  reset_recovery_pkg::flash_state_t fl_next;
  logic [19:0] ab_reg;
  logic [19:0] ab_next;
  logic resetting;
  logic start_ok;

  assign resetting = (state_reg != reset_recovery_pkg::st_run);
  assign start_ok = flash_start_in && !below_lockout_in && !resetting; // [RULE6]

  // read, busy, abort back to read
  always_comb
  begin
    fl_next = fl_reg;
    ab_next = ab_reg;
    case (fl_reg)
      reset_recovery_pkg::fl_read:
      begin
        ab_next = 20'h00000;
        if (start_ok)
          fl_next = reset_recovery_pkg::fl_busy;
      end
      reset_recovery_pkg::fl_busy:
      begin
        if (low_long)
          fl_next = reset_recovery_pkg::fl_abort; // [RULE12]
        else if (flash_done_in)
          fl_next = reset_recovery_pkg::fl_read;
      end
      reset_recovery_pkg::fl_abort:
      begin
        ab_next = ab_reg + 20'h00001;
        if (ab_reg + 20'h00001 >= 20'(abort_cycles_p))
          fl_next = reset_recovery_pkg::fl_read; // [RULE12]
      end
      default:
        fl_next = reset_recovery_pkg::fl_read;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fl_reg <= reset_recovery_pkg::fl_read; // [RULE4]
      ab_reg <= 20'h00000;
    end
    else
    begin
      fl_reg <= fl_next;
      ab_reg <= ab_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers cleared by reset type
  logic [7:0] pm0_next;
  logic [7:0] pm2_next;
  logic [7:0] vm_next;
  logic [7:0] oth_next;
  logic in_hold;

  assign in_hold = (state_reg == reset_recovery_pkg::st_hold);

  // reset-type clearing, writes only while running, frozen in power-down
  always_comb
  begin
    pm0_next = power_mode_reg_zero_out;
    pm2_next = power_mode_reg_two_out;
    vm_next = memory_mapping_reg_out;
    oth_next = other_reg_out;
    if (in_hold)
    begin
      if (poweron_out)
      begin
        pm0_next = reset_recovery_pkg::reg_clear_val; // [RULE10]
        pm2_next = reset_recovery_pkg::reg_clear_val; // [RULE10]
      end
      oth_next = reset_recovery_pkg::reg_clear_val; // [RULE10]
      vm_next = vm_init_in;
      vm_next[reset_recovery_pkg::sram_code_space_bit] = 1'b0; // [RULE11]
    end
    else if (reg_wr_in && !resetting && !power_down_in)
    begin
      case (reg_wr_sel_in)
        2'h0: pm0_next = reg_wdata_in;
        2'h1: pm2_next = reg_wdata_in;
        2'h2: vm_next = reg_wdata_in;
        default: oth_next = reg_wdata_in;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      power_mode_reg_zero_out <= reset_recovery_pkg::reg_clear_val;
      power_mode_reg_two_out <= reset_recovery_pkg::reg_clear_val;
      memory_mapping_reg_out <= reset_recovery_pkg::reg_clear_val;
      other_reg_out <= reset_recovery_pkg::reg_clear_val;
    end
    else
    begin
      power_mode_reg_zero_out <= pm0_next;
      power_mode_reg_two_out <= pm2_next;
      memory_mapping_reg_out <= vm_next;
      other_reg_out <= oth_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and status outputs, all registered
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      in_reset_out <= 1'b1;
      access_ok_out <= 1'b0;
      flash_read_mode_out <= 1'b1;
      flash_busy_out <= 1'b0;
      flash_abort_out <= 1'b0;
      write_start_out <= 1'b0;
      select_inhibit_out <= 1'b1;
      pld_out <= reset_recovery_pkg::reg_clear_val;
      io_out <= reset_recovery_pkg::reg_clear_val;
      io_oe_n_out <= 8'hff;
      addr_oe_n_out <= 1'b1;
      data_oe_n_out <= 1'b1;
    end
    else
    begin
      in_reset_out <= (state_next != reset_recovery_pkg::st_run); // [RULE3]
      access_ok_out <= (state_next == reset_recovery_pkg::st_run); // [RULE3]
      flash_read_mode_out <= (fl_next == reset_recovery_pkg::fl_read); // [RULE4]
      flash_busy_out <= (fl_next == reset_recovery_pkg::fl_busy);
      flash_abort_out <= (fl_next == reset_recovery_pkg::fl_abort);
      write_start_out <= start_ok && (fl_reg == reset_recovery_pkg::fl_read); // [RULE6]
      select_inhibit_out <= poweron_next; // selects gated during power-up [RULE5]
      if (cfg_next)
        pld_out <= pld_eqn_in; // follows equations, power-down too [RULE8]
      if (state_next != reset_recovery_pkg::st_run)
      begin
        io_oe_n_out <= 8'hff; // [RULE9]
        addr_oe_n_out <= 1'b1; // [RULE9]
        data_oe_n_out <= 1'b1; // [RULE9]
      end
      else if (power_down_in)
      begin
        data_oe_n_out <= 1'b1; // io and address enables kept, data tri-stated [RULE9]
      end
      else
      begin
        io_out <= io_out_in;
        io_oe_n_out <= ~io_dir_in;
        addr_oe_n_out <= 1'b0;
        data_oe_n_out <= 1'b0;
      end
    end
  end

endmodule

// >>> verification/reset_recovery_props.sv
/*
  checker for the reset recovery sequencer, bound to its top module.
  assumes one clock domain and the synchronous reset rst_in.
*/
`timescale 1ns/1ps
module reset_recovery_props #(
  parameter int abort_cycles_p = 20
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic power_down_in,
  input wire logic below_lockout_in,
  input wire logic flash_start_in,
  input wire logic [7:0] vm_init_in,
  input wire logic [7:0] pld_eqn_in,
  input wire logic in_reset_out,
  input wire logic access_ok_out,
  input wire logic poweron_out,
  input wire logic config_loaded_out,
  input wire logic flash_read_mode_out,
  input wire logic flash_busy_out,
  input wire logic flash_abort_out,
  input wire logic write_start_out,
  input wire logic [7:0] power_mode_reg_zero_out,
  input wire logic [7:0] power_mode_reg_two_out,
  input wire logic [7:0] memory_mapping_reg_out,
  input wire logic [7:0] other_reg_out,
  input wire logic [7:0] pld_out,
  input wire logic [7:0] io_oe_n_out,
  input wire logic addr_oe_n_out,
  input wire logic data_oe_n_out
);
  localparam int abort_win = abort_cycles_p + 4;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////////
  // access and recovery timing
  property p_access_inv;
    access_ok_out != in_reset_out;
  endproperty
  a_access_inv: assert property (p_access_inv) else $error("access flag not inverse");
  property p_recovery;
    $rose(reset_pin_n_in) && in_reset_out |-> in_reset_out [*8] ##[1:12] access_ok_out;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery length wrong");

  // flash control
  property p_lockout;
    write_start_out |-> $past(flash_start_in) && !$past(below_lockout_in);
  endproperty
  a_lockout: assert property (p_lockout) else $error("write began below lockout");
  property p_flash_onehot;
    $onehot({flash_read_mode_out, flash_busy_out, flash_abort_out});
  endproperty
  a_flash_onehot: assert property (p_flash_onehot) else $error("flash state not one-hot");
  property p_abort_end;
    $rose(flash_abort_out) |-> ##[1:abort_win] flash_read_mode_out;
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("abort did not end in read");

  // pins and registers
  property p_pins_safe;
    in_reset_out [*2] |-> io_oe_n_out == 8'hff && addr_oe_n_out && data_oe_n_out;
  endproperty
  a_pins_safe: assert property (p_pins_safe) else $error("pins driven in reset");
  property p_warm_keep;
    in_reset_out && $past(in_reset_out) && !poweron_out |->
      $stable(power_mode_reg_zero_out) && $stable(power_mode_reg_two_out);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("power mode changed in warm reset");
  property p_clear_po;
    $rose(access_ok_out) && $past(poweron_out) |->
      power_mode_reg_zero_out == 8'h00 && power_mode_reg_two_out == 8'h00;
  endproperty
  a_clear_po: assert property (p_clear_po) else $error("power mode not cleared");
  property p_other_clear;
    $rose(access_ok_out) |-> other_reg_out == 8'h00;
  endproperty
  a_other_clear: assert property (p_other_clear) else $error("register not cleared");
  property p_vm;
    $rose(access_ok_out) |-> memory_mapping_reg_out == (vm_init_in & 8'hfe);
  endproperty
  a_vm: assert property (p_vm) else $error("mapping register not loaded");
  property p_pld;
    config_loaded_out |=> pld_out == $past(pld_eqn_in);
  endproperty
  a_pld: assert property (p_pld) else $error("logic outputs not following");
  property p_pd_data;
    power_down_in |=> data_oe_n_out;
  endproperty
  a_pd_data: assert property (p_pd_data) else $error("data port driven in power-down");

  // main scenarios reached
  c_warm: cover property ($rose(in_reset_out) && !poweron_out);
  c_abort: cover property ($rose(flash_abort_out));
  c_write: cover property ($rose(write_start_out));
endmodule

////////////////////////////////////////////////////////////////////////////
bind reset_recovery_sequencer reset_recovery_props #(.abort_cycles_p(abort_cycles_p)) i_props (
  .clk_in, .rst_in, .reset_pin_n_in, .power_down_in, .below_lockout_in, .flash_start_in,
  .vm_init_in, .pld_eqn_in, .in_reset_out, .access_ok_out, .poweron_out, .config_loaded_out,
  .flash_read_mode_out, .flash_busy_out, .flash_abort_out, .write_start_out,
  .power_mode_reg_zero_out, .power_mode_reg_two_out, .memory_mapping_reg_out, .other_reg_out,
  .pld_out, .io_oe_n_out, .addr_oe_n_out, .data_oe_n_out
);

// >>> verification/reset_source_model.sv
/*
  model of the external reset circuit driving the active-low reset pin.
  assumes the pin has a pull-up, so it reads high whenever not pulled low.
*/
`timescale 1ns/1ps
module reset_source_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [19:0] len_in,
  output logic reset_pin_n_out
);
  logic [19:0] left_reg = 20'h00000;

  ////////////////////////////////////////////////////////////////////////////
  // hold the pin low for the requested count of cycles
  always @(posedge clk_in)
  begin
    if (go_in)
      left_reg <= len_in;
    else if (left_reg != 20'h00000)
      left_reg <= left_reg - 20'h00001;
  end

  // pull-up wins once the count runs out
  assign reset_pin_n_out = (left_reg == 20'h00000);
endmodule

// >>> verification/tb.sv
/*
  self-checking bench for the reset recovery sequencer.
  assumes a 100 MHz clock and shortened power-on and abort counts.
*/
`timescale 1ns/1ps
module tb;
  logic clk_in, rst_in, reset_pin_n_in, below_lockout_in, power_down_in;
  logic flash_start_in, flash_done_in, reg_wr_in, go;
  logic saw_abort = 1'b0;
  logic [1:0] reg_wr_sel_in;
  logic [7:0] vm_init_in, reg_wdata_in, pld_eqn_in, io_out_in, io_dir_in;
  logic [19:0] len;
  logic in_reset_out, access_ok_out, flash_read_mode_out, flash_busy_out, flash_abort_out;
  logic write_start_out, addr_oe_n_out, data_oe_n_out, power_good_out, select_inhibit_out;
  logic [7:0] power_mode_reg_zero_out, power_mode_reg_two_out, memory_mapping_reg_out;
  logic [7:0] other_reg_out, pld_out, io_out, io_oe_n_out;
  int err_total = 0;
  int checks_done = 0;
  typedef struct {logic [1:0] sel; logic [7:0] data;} row_t;
  row_t rows [4] = '{'{2'h0, 8'h3a}, '{2'h1, 8'h5c}, '{2'h2, 8'ha7}, '{2'h3, 8'h96}};

  reset_source_model i_src (.clk_in, .go_in(go), .len_in(len), .reset_pin_n_out(reset_pin_n_in));
  reset_recovery_sequencer #(.poweron_cycles_p(40), .abort_cycles_p(20)) i_dut (
    .clk_in, .rst_in, .reset_pin_n_in, .below_lockout_in, .power_down_in, .vm_init_in,
    .flash_start_in, .flash_done_in, .reg_wr_sel_in, .reg_wr_in, .reg_wdata_in, .pld_eqn_in,
    .io_out_in, .io_dir_in, .in_reset_out, .access_ok_out, .poweron_out(), .power_good_out,
    .config_loaded_out(), .flash_read_mode_out, .flash_busy_out, .flash_abort_out,
    .write_start_out, .select_inhibit_out, .power_mode_reg_zero_out, .power_mode_reg_two_out,
    .memory_mapping_reg_out, .other_reg_out, .pld_out, .io_out, .io_oe_n_out,
    .addr_oe_n_out, .data_oe_n_out
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, abort monitor and watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    if (flash_abort_out === 1'b1)
      saw_abort <= 1'b1;
  initial
  begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // pin pulse, returning once the pin is high again
  task pulse(input logic [19:0] n);
    go <= 1'b1;
    len <= n;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (n + 2) @(posedge clk_in);
  endtask
  task wait_ready;
    int k;
    repeat (4) @(posedge clk_in);
    for (k = 0; k < 100 && access_ok_out !== 1'b1; k++)
      @(posedge clk_in);
  endtask
  task reg_write(input logic [1:0] s, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_wr_sel_in <= s;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task start_flash(input logic exp);
    logic seen;
    seen = 1'b0;
    flash_start_in <= 1'b1;
    @(posedge clk_in);
    flash_start_in <= 1'b0;
    repeat (3)
    begin
      @(posedge clk_in);
      seen = seen | write_start_out;
    end
    check8("write_start", {7'h00, exp}, {7'h00, seen});
  endtask
  task power_on;
    rst_in <= 1'b1; // strobes and starts stay low through power-up
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    pulse(20'd60);
    check8("sel_inhibit", 8'h01, {7'h00, select_inhibit_out});
    check8("io_oe_n_rst", 8'hff, io_oe_n_out);
    wait_ready();
  endtask
  function automatic logic [7:0] view(input logic [1:0] s);
    case (s)
      2'h0: return power_mode_reg_zero_out;
      2'h1: return power_mode_reg_two_out;
      2'h2: return memory_mapping_reg_out;
      default: return other_reg_out;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_in, below_lockout_in, power_down_in, flash_start_in, flash_done_in} = 5'h10;
    {reg_wr_in, go, reg_wr_sel_in, len} = '0;
    {vm_init_in, reg_wdata_in, pld_eqn_in} = {8'h5b, 8'h00, 8'hc3};
    {io_out_in, io_dir_in} = {8'h55, 8'h0f};
    power_on();
    check8("pm_zero", 8'h00, power_mode_reg_zero_out);
    check8("pld", 8'hc3, pld_out);
    check8("sel_inhibit", 8'h00, {7'h00, select_inhibit_out});
    check8("power_good", 8'h01, {7'h00, power_good_out});
    check8("io_out", 8'h55, io_out);
    check8("io_oe_n", 8'hf0, io_oe_n_out);
    check8("read_mode", 8'h01, {7'h00, flash_read_mode_out});
    foreach (rows[i])
    begin
      reg_write(rows[i].sel, rows[i].data);
      check8("reg", rows[i].data, view(rows[i].sel));
    end
    pulse(20'd20);
    wait_ready();
    check8("pm_zero", 8'h3a, power_mode_reg_zero_out);
    check8("pm_two", 8'h5c, power_mode_reg_two_out);
    check8("mapping", 8'h5a, memory_mapping_reg_out);
    check8("other", 8'h00, other_reg_out);
    pulse(20'd5);
    repeat (20) @(posedge clk_in);
    check8("glitch", 8'h00, {7'h00, in_reset_out});
    below_lockout_in <= 1'b1;
    start_flash(1'b0);
    below_lockout_in <= 1'b0;
    start_flash(1'b1);
    flash_done_in <= 1'b1;
    @(posedge clk_in);
    flash_done_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check8("read_mode", 8'h01, {7'h00, flash_read_mode_out});
    start_flash(1'b1);
    pulse(20'd20);
    wait_ready();
    repeat (30) @(posedge clk_in);
    check8("abort_seen", 8'h01, {7'h00, saw_abort});
    check8("read_mode", 8'h01, {7'h00, flash_read_mode_out});
    power_down_in <= 1'b1;
    reg_write(2'h3, 8'h11);
    check8("frozen", 8'h00, other_reg_out);
    check8("data_oe_n", 8'h01, {7'h00, data_oe_n_out});
    pld_eqn_in <= 8'h3c;
    repeat (2) @(posedge clk_in);
    check8("pld_pd", 8'h3c, pld_out);
    check8("io_oe_n_pd", 8'hf0, io_oe_n_out);
    power_down_in <= 1'b0;
    power_on();
    check8("pm_two", 8'h00, power_mode_reg_two_out);
    tally_and_finish();
  end
endmodule
